// File: pkg/fppio_pkg.sv
package fppio_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0]  IDX_PORT_A_LATCH     = 4'h0;
    localparam logic [3:0]  IDX_PORT_B_LATCH     = 4'h1;
    localparam logic [3:0]  IDX_PORT_C_LATCH     = 4'h2;
    localparam logic [3:0]  IDX_PORT_D_LATCH     = 4'h3;
    localparam logic [3:0]  IDX_PORT_A_DIRECTION = 4'h4;
    localparam logic [3:0]  IDX_PORT_B_DIRECTION = 4'h5;
    localparam logic [3:0]  IDX_PORT_C_DIRECTION = 4'h6;
    localparam logic [3:0]  IDX_PORT_D_DIRECTION = 4'h7;
    localparam logic [3:0]  IDX_LED_DRIVE_SELECT = 4'h8;
    localparam int          ADDR_IDX_LSB         = 2;
    localparam int          ADDR_W               = 6;

    localparam logic [7:0]  DIRECTION_RESET      = 8'h00;
    localparam logic [7:0]  LED_SELECT_RESET     = 8'h00;
    localparam int          PORT_COUNT           = 4;
    localparam int          PORT_WIDTH           = 8;
    localparam int          PIN_COUNT            = 32;

    // Pins that only ever sink current when driving
    localparam logic [31:0] OPEN_DRAIN_MASK      = 32'h00c00f00;

    // Pin positions inside the flat 32-bit pin vectors
    localparam int          PORT_A_BASE          = 0;
    localparam int          PORT_B_BASE          = 8;
    localparam int          PORT_C_BASE          = 16;
    localparam int          PORT_D_BASE          = 24;
    localparam logic [4:0]  CONVERTER_PINS       = 5'h08;

    localparam logic [1:0]  RESP_OKAY            = 2'h0;
    localparam logic [1:0]  RESP_SLVERR          = 2'h2;

    typedef struct packed {
        logic [3:0][7:0] latch;
        logic [3:0][7:0] dir;
        logic [7:0]      led;
        logic [31:0]     sync1;
        logic [31:0]     sync2;
        logic            aw_held;
        logic [3:0]      aw_idx;
        logic            w_held;
        logic [7:0]      w_data;
        logic            w_lane0;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [1:0]      rresp;
        logic [7:0]      rdata;
    } fppio_state_type;
endpackage

// File: rtl/fppio_top.sv
`timescale 1ns/100ps
module fppio_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [4:0]  converter_channel_select,
    input  wire logic        two_wire_bus_enable,
    input  wire logic        serial_iface_enable,
    input  wire logic [7:0]  timer_edge_level_select,
    input  wire logic        second_irq_mask,
    input  wire logic        spi_unit_enable,
    input  wire logic        ir_serial_enable,
    input  wire logic [7:0]  keypad_pin_irq_enable,
    input  wire logic [31:0] periph_out,
    input  wire logic [31:0] periph_oe,
    input  wire logic [31:0] pin_in,
    output logic [31:0]      pin_out,
    output logic [31:0]      pin_oe,
    output logic [31:0]      pin_level,
    output logic [7:0]       led_high_sink
);
    fppio_pkg::fppio_state_type s_ff;
    fppio_pkg::fppio_state_type nxt_s;

    logic [31:0] take;
    logic [31:0] dir_flat;
    logic [31:0] latch_flat;
    logic        wr_commit;
    logic        rd_accept;
    logic [3:0]  ar_idx;

    // True for an index that holds a register
    function automatic logic fppio_mapped(input logic [3:0] idx);
        fppio_mapped = (idx <= fppio_pkg::IDX_LED_DRIVE_SELECT);
    endfunction

    // Port of a latch or direction index
    function automatic logic [1:0] fppio_port(input logic [3:0] idx);
        fppio_port = idx[1:0];
    endfunction

    assign dir_flat   = s_ff.dir;
    assign latch_flat = s_ff.latch;
    assign ar_idx     = s_axi_araddr[fppio_pkg::ADDR_W-1:fppio_pkg::ADDR_IDX_LSB];

    // Peripheral takeover per pin
    always_comb begin
        take = 32'h00000000;
        if (converter_channel_select < fppio_pkg::CONVERTER_PINS) begin
            take[converter_channel_select[2:0]] = 1'b1;
        end
        take[fppio_pkg::PORT_B_BASE+0] = two_wire_bus_enable;
        take[fppio_pkg::PORT_B_BASE+1] = two_wire_bus_enable;
        take[fppio_pkg::PORT_B_BASE+2] = serial_iface_enable;
        take[fppio_pkg::PORT_B_BASE+3] = serial_iface_enable;
        for (int t = 0; t < 4; t++) begin
            take[fppio_pkg::PORT_B_BASE+4+t] = |timer_edge_level_select[2*t +: 2];
        end
        // Interrupt input owns the pin while it is unmasked
        take[fppio_pkg::PORT_C_BASE+0] = ~second_irq_mask;
        take[fppio_pkg::PORT_C_BASE+2 +: 4] = {4{spi_unit_enable}};
        take[fppio_pkg::PORT_C_BASE+6 +: 2] = {2{ir_serial_enable}};
        take[fppio_pkg::PORT_D_BASE +: 8] = keypad_pin_irq_enable;
    end

    // Pin drivers
    always_comb begin
        logic v;
        logic e;
        v = 1'b0;
        e = 1'b0;
        pin_out = 32'h00000000;
        pin_oe  = 32'h00000000;
        for (int i = 0; i < fppio_pkg::PIN_COUNT; i++) begin
            if (take[i]) begin
                v = periph_out[i];
                // Converter pins are analog, so no driver at all
                e = (i < fppio_pkg::PORT_B_BASE) ? 1'b0 : periph_oe[i];
            end else begin
                v = latch_flat[i];
                e = dir_flat[i];
            end
            if (fppio_pkg::OPEN_DRAIN_MASK[i]) begin
                pin_out[i] = 1'b0;
                pin_oe[i]  = e & ~v;
            end else begin
                pin_out[i] = v;
                pin_oe[i]  = e;
            end
        end
    end

    assign pin_level     = s_ff.sync2;
    assign led_high_sink = s_ff.led & s_ff.dir[0] & ~take[7:0];

    assign s_axi_awready = ~s_ff.aw_held & ~s_ff.bvalid;
    assign s_axi_wready  = ~s_ff.w_held & ~s_ff.bvalid;
    assign s_axi_arready = ~s_ff.rvalid;
    assign s_axi_bvalid  = s_ff.bvalid;
    assign s_axi_bresp   = s_ff.bresp;
    assign s_axi_rvalid  = s_ff.rvalid;
    assign s_axi_rresp   = s_ff.rresp;
    assign s_axi_rdata   = {24'h000000, s_ff.rdata};

    assign wr_commit = s_ff.aw_held & s_ff.w_held & ~s_ff.bvalid;
    assign rd_accept = s_axi_arvalid & ~s_ff.rvalid;

    always_comb begin
        nxt_s = s_ff;
        // Pins are asynchronous, two flops before any reader
        nxt_s.sync1 = pin_in;
        nxt_s.sync2 = s_ff.sync1;

        if (s_axi_awvalid & s_axi_awready) begin
            nxt_s.aw_held = 1'b1;
            nxt_s.aw_idx  = s_axi_awaddr[fppio_pkg::ADDR_W-1:fppio_pkg::ADDR_IDX_LSB];
        end
        if (s_axi_wvalid & s_axi_wready) begin
            nxt_s.w_held  = 1'b1;
            nxt_s.w_data  = s_axi_wdata[7:0];
            nxt_s.w_lane0 = s_axi_wstrb[0];
        end

        // Write lands once both halves are held, one access per write
        if (wr_commit) begin
            nxt_s.aw_held = 1'b0;
            nxt_s.w_held  = 1'b0;
            nxt_s.bvalid  = 1'b1;
            nxt_s.bresp   = fppio_pkg::RESP_OKAY;
            if (!fppio_mapped(s_ff.aw_idx)) begin
                nxt_s.bresp = fppio_pkg::RESP_SLVERR;
            end else if (s_ff.w_lane0) begin
                if (s_ff.aw_idx == fppio_pkg::IDX_LED_DRIVE_SELECT) begin
                    nxt_s.led = s_ff.w_data;
                end else if (s_ff.aw_idx[2]) begin
                    nxt_s.dir[fppio_port(s_ff.aw_idx)] = s_ff.w_data;
                end else begin
                    // Latch loads whatever the direction
                    nxt_s.latch[fppio_port(s_ff.aw_idx)] = s_ff.w_data;
                end
            end
        end else if (s_ff.bvalid & s_axi_bready) begin
            nxt_s.bvalid = 1'b0;
        end

        if (rd_accept) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp  = fppio_pkg::RESP_OKAY;
            nxt_s.rdata  = 8'h00;
            if (!fppio_mapped(ar_idx)) begin
                nxt_s.rresp = fppio_pkg::RESP_SLVERR;
            end else if (ar_idx == fppio_pkg::IDX_LED_DRIVE_SELECT) begin
                nxt_s.rdata = s_ff.led;
            end else if (ar_idx[2]) begin
                nxt_s.rdata = s_ff.dir[fppio_port(ar_idx)];
            end else begin
                nxt_s.rdata = (s_ff.latch[fppio_port(ar_idx)] & s_ff.dir[fppio_port(ar_idx)])
                            | (s_ff.sync2[8*fppio_port(ar_idx) +: 8]
                               & ~s_ff.dir[fppio_port(ar_idx)]);
            end
        end else if (s_ff.rvalid & s_axi_rready) begin
            nxt_s.rvalid = 1'b0;
        end

        if (!aresetn) begin
            // Latches are left alone; software must load them
            nxt_s.latch   = s_ff.latch;
            nxt_s.dir     = {4{fppio_pkg::DIRECTION_RESET}};
            nxt_s.led     = fppio_pkg::LED_SELECT_RESET;
            nxt_s.aw_held = 1'b0;
            nxt_s.w_held  = 1'b0;
            nxt_s.bvalid  = 1'b0;
            nxt_s.bresp   = fppio_pkg::RESP_OKAY;
            nxt_s.rvalid  = 1'b0;
            nxt_s.rresp   = fppio_pkg::RESP_OKAY;
            nxt_s.rdata   = 8'h00;
            nxt_s.aw_idx  = 4'h0;
            nxt_s.w_data  = 8'h00;
            nxt_s.w_lane0 = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        s_ff <= nxt_s;
    end

    default clocking cb @(posedge aclk); endclocking

    a_dir_reset_clear: assert property (
        !aresetn |=> (s_ff.dir == 32'h00000000))
        else $error("direction not cleared by reset");

    // Power-up latches are unknown, so only a reset entered mid-run is checked
    a_latch_reset_hold: assert property (
        (!aresetn && $past(aresetn)) |=> (s_ff.latch == $past(s_ff.latch)))
        else $error("latch changed under reset");

    a_driver_follow_dir: assert property (disable iff (!aresetn)
        ((pin_oe & ~take & ~fppio_pkg::OPEN_DRAIN_MASK)
         == (dir_flat & ~take & ~fppio_pkg::OPEN_DRAIN_MASK)))
        else $error("driver enable differs from direction");

    a_open_drain_low: assert property (disable iff (!aresetn)
        ((pin_out & fppio_pkg::OPEN_DRAIN_MASK) == 32'h00000000))
        else $error("open-drain pin driven high");

    a_converter_release: assert property (disable iff (!aresetn)
        ((pin_oe[7:0] & take[7:0]) == 8'h00))
        else $error("converter pin still driven");

    a_led_needs_output: assert property (disable iff (!aresetn)
        ((led_high_sink & ~s_ff.dir[0]) == 8'h00))
        else $error("LED drive on an input pin");

    a_read_mixes_pins: assert property (disable iff (!aresetn)
        (rd_accept && ar_idx == fppio_pkg::IDX_PORT_D_LATCH) |=>
        (s_axi_rvalid && s_axi_rdata[7:0] == (($past(s_ff.latch[3]) & $past(s_ff.dir[3]))
                       | ($past(s_ff.sync2[31:24]) & ~$past(s_ff.dir[3])))))
        else $error("port read value wrong");

    a_write_one_access: assert property (disable iff (!aresetn)
        (wr_commit && s_ff.w_lane0 && s_ff.aw_idx == fppio_pkg::IDX_PORT_B_LATCH) |=>
        (s_axi_bvalid && s_ff.latch[1] == $past(s_ff.w_data)))
        else $error("latch write not completed");

    a_write_resp_next: assert property (disable iff (!aresetn)
        wr_commit |=> s_axi_bvalid)
        else $error("write response late");

    a_read_one_cycle: assert property (disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read data late");

    a_bvalid_holds: assert property (disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=>
        (s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("write response dropped early");

    a_rvalid_holds: assert property (disable iff (!aresetn)
        (s_axi_rvalid && !s_axi_rready) |=>
        (s_axi_rvalid && $stable(s_axi_rdata)
         && $stable(s_axi_rresp)))
        else $error("read data dropped early");

    a_write_busy_stall: assert property (disable iff (!aresetn)
        s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
        else $error("write taken while response pending");

    a_read_busy_stall: assert property (disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");

    a_write_slverr: assert property (disable iff (!aresetn)
        (wr_commit && !fppio_mapped(s_ff.aw_idx)) |=>
        (s_axi_bresp == fppio_pkg::RESP_SLVERR))
        else $error("unmapped write not refused");

    a_read_slverr: assert property (disable iff (!aresetn)
        (rd_accept && !fppio_mapped(ar_idx)) |=>
        ((s_axi_rresp == fppio_pkg::RESP_SLVERR)
         && (s_axi_rdata == 32'h00000000)))
        else $error("unmapped read not refused");

    a_read_okay: assert property (disable iff (!aresetn)
        (rd_accept && fppio_mapped(ar_idx)) |=>
        (s_axi_rresp == fppio_pkg::RESP_OKAY))
        else $error("mapped read refused");

    a_rdata_byte_wide: assert property (disable iff (!aresetn)
        s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h000000))
        else $error("read data wider than a byte");

    a_latch_any_dir: assert property (disable iff (!aresetn)
        (wr_commit && s_ff.w_lane0 && s_ff.aw_idx == fppio_pkg::IDX_PORT_A_LATCH) |=>
        (s_ff.latch[0] == $past(s_ff.w_data)))
        else $error("port a latch write lost");

    a_dir_write_lands: assert property (disable iff (!aresetn)
        (wr_commit && s_ff.w_lane0 && s_ff.aw_idx == fppio_pkg::IDX_PORT_C_DIRECTION) |=>
        (s_ff.dir[2] == $past(s_ff.w_data)))
        else $error("direction write lost");

    a_strobe_off_hold: assert property (disable iff (!aresetn)
        (wr_commit && !s_ff.w_lane0) |=>
        ((s_ff.dir == $past(s_ff.dir)) && (s_ff.led == $past(s_ff.led))))
        else $error("write without strobe changed a register");

    a_taken_periph_drive: assert property (disable iff (!aresetn)
        ((pin_oe & take & ~fppio_pkg::OPEN_DRAIN_MASK & 32'hffffff00)
         == (periph_oe & take & ~fppio_pkg::OPEN_DRAIN_MASK & 32'hffffff00)))
        else $error("taken pin enable not from peripheral");

    a_taken_periph_value: assert property (disable iff (!aresetn)
        ((pin_out & take & ~fppio_pkg::OPEN_DRAIN_MASK & 32'hffffff00)
         == (periph_out & take & ~fppio_pkg::OPEN_DRAIN_MASK & 32'hffffff00)))
        else $error("taken pin value not from peripheral");

    a_od_drive_low: assert property (disable iff (!aresetn)
        ((pin_oe & ~take & fppio_pkg::OPEN_DRAIN_MASK)
         == (dir_flat & ~latch_flat & ~take & fppio_pkg::OPEN_DRAIN_MASK)))
        else $error("open-drain pin enable wrong");

    a_reset_inputs: assert property (
        !aresetn |=> ((pin_oe & ~take) == 32'h00000000))
        else $error("pin driven after reset");

    a_led_not_taken: assert property (disable iff (!aresetn)
        ((led_high_sink & take[7:0]) == 8'h00))
        else $error("LED drive on a converter pin");

    c_write_done: cover property (disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
    c_read_done:  cover property (disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
    c_converter:  cover property (disable iff (!aresetn) |take[7:0] && |s_ff.dir[0]);
    c_open_drain: cover property (disable iff (!aresetn) |(pin_oe & fppio_pkg::OPEN_DRAIN_MASK));
    c_bus_error:  cover property (disable iff (!aresetn) s_axi_bvalid && s_axi_bresp[1]);
endmodule

// File: testbench/fppio_pins.sv
`timescale 1ns/100ps
// Far side of the pins; undriven plain pins show the inverse of their current pin_out value
module fppio_pins (
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] ext_drv,
    input  wire logic [31:0] ext_val,
    output logic [31:0]      pin_in
);
    // Open-drain pins need an external pull-up to read high
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
        | (~pin_oe & ~ext_drv & (fppio_pkg::OPEN_DRAIN_MASK | ~pin_out));
endmodule

// File: testbench/fppio_top_bench.sv
`timescale 1ns/100ps
module fppio_top_bench;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [5:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, pout = 0, poe = 0, edrv = 0, eval = 0;
    logic [31:0] pin_in, pin_out, pin_oe;
    logic [31:0] plvl;
    logic [3:0]  strb = 4'hf;
    logic [1:0]  bresp, rresp, r;
    logic [7:0]  led, d;
    logic [4:0]  ch = 5'h1f;
    logic [7:0]  tmr = 0, kbd = 0;
    logic        twb = 0, ser = 0, irqm = 1, spi = 0, irs = 0;
    int          failures = 0, n_tests = 0;
    always #4 aclk = ~aclk;
    fppio_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .converter_channel_select(ch), .two_wire_bus_enable(twb),
        .serial_iface_enable(ser), .timer_edge_level_select(tmr),
        .second_irq_mask(irqm), .spi_unit_enable(spi), .ir_serial_enable(irs),
        .keypad_pin_irq_enable(kbd), .periph_out(pout), .periph_oe(poe),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(plvl),
        .led_high_sink(led));
    fppio_pins PINS (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(edrv),
        .ext_val(eval), .pin_in(pin_in));
    task check(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task results();
        $display("mismatches %0d of %0d checks", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task wr(input logic [3:0] idx, input logic [7:0] v);
        @(posedge aclk);
        awaddr <= {idx, 2'b00}; wdata <= {24'h0, v}; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid);
        r = bresp;
        bready <= 0;
    endtask
    task rd(input logic [3:0] idx);
        @(posedge aclk);
        araddr <= {idx, 2'b00}; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid);
        d = rdata[7:0]; r = rresp;
        rready <= 0;
    endtask
    task t_reset_dirs();
        for (int i = 4; i < 7; i++) begin
            rd(i[3:0]); check("direction after reset", d, 8'h00);
        end
        check("pin drive after reset", pin_oe, 32'h0);
    endtask
    task t_port_a();
        edrv <= 32'hff; eval <= 32'h5a;
        repeat (4) @(posedge aclk);
        rd(fppio_pkg::IDX_PORT_A_LATCH); check("input level read", d, 8'h5a);
        wr(fppio_pkg::IDX_PORT_A_LATCH, 8'hc3);
        rd(fppio_pkg::IDX_PORT_A_LATCH); check("input after write", d, 8'h5a);
        edrv <= 0;
        wr(fppio_pkg::IDX_PORT_A_DIRECTION, 8'hff);
        rd(fppio_pkg::IDX_PORT_A_LATCH); check("latch read", d, 8'hc3);
        check("port a drive", pin_oe[7:0], 8'hff);
        check("port a value", pin_out[7:0], 8'hc3);
        check("pin level", plvl[7:0], 8'hc3);
        wr(fppio_pkg::IDX_LED_DRIVE_SELECT, 8'hff);
        ch <= 5'h03;
        @(posedge aclk); @(negedge aclk);
        check("converter pin freed", pin_oe[7:0], 8'hf7);
        check("other pins digital", pin_out[7:0] & 8'hf7, 8'hc3 & 8'hf7);
        check("led sink", led, 8'hf7);
        wr(fppio_pkg::IDX_PORT_A_DIRECTION, 8'h0f);
        check("led needs output", led, 8'h07);
    endtask
    task t_open_drain();
        wr(fppio_pkg::IDX_PORT_B_LATCH, 8'h35);
        wr(fppio_pkg::IDX_PORT_B_DIRECTION, 8'hff);
        check("port b value", pin_out[15:8], 8'h30);
        check("port b drive", pin_oe[15:8], 8'hfa);
        rd(fppio_pkg::IDX_PORT_B_LATCH); check("port b read", d, 8'h35);
    endtask
    task t_takeover();
        wr(fppio_pkg::IDX_PORT_C_LATCH, 8'hff);
        wr(fppio_pkg::IDX_PORT_C_DIRECTION, 8'h00);
        spi <= 1; poe <= 32'h003c0000; pout <= 32'h00140000;
        @(posedge aclk); @(negedge aclk);
        check("spi pins drive", pin_oe[23:16], 8'h3c);
        check("spi pins value", pin_out[23:16] & 8'h3c, 8'h14);
        spi <= 0;
        twb <= 1;
        ser <= 1;
        tmr <= 8'h0c;
        irqm <= 0;
        irs <= 1;
        kbd <= 8'h81;
        poe <= 32'hffffffff;
        pout <= 32'h00000100;
        @(posedge aclk);
        @(negedge aclk);
        check("port b takeover drive", pin_oe[15:8], 8'hfe);
        check("port b takeover value", pin_out[15:8], 8'h10);
        check("port c takeover drive", pin_oe[23:16], 8'hc1);
        check("port c takeover value", pin_out[23:16], 8'h3e);
        check("port d takeover drive", pin_oe[31:24], 8'h81);
        twb <= 0;
        ser <= 0;
        tmr <= 8'h00;
        irqm <= 1;
        irs <= 0;
        kbd <= 8'h00;
        poe <= 32'h00000000;
        pout <= 32'h00000000;
    endtask
    task t_bus_errors();
        rd(4'h9); check("unmapped read resp", r, fppio_pkg::RESP_SLVERR);
        check("unmapped read data", d, 8'h00);
        wr(4'h9, 8'h11); check("unmapped write resp", r, fppio_pkg::RESP_SLVERR);
        wr(fppio_pkg::IDX_PORT_D_LATCH, 8'h3c); check("write resp", r, fppio_pkg::RESP_OKAY);
        strb <= 4'he;
        wr(fppio_pkg::IDX_PORT_B_DIRECTION, 8'h00);
        strb <= 4'hf;
        check("unstrobed write resp", r, fppio_pkg::RESP_OKAY);
        rd(fppio_pkg::IDX_PORT_B_DIRECTION);
        check("unstrobed write ignored", d, 8'hff);
    endtask
    task t_latch_keeps();
        @(posedge aclk); aresetn <= 0;
        repeat (3) @(posedge aclk); aresetn <= 1;
        rd(fppio_pkg::IDX_PORT_B_DIRECTION); check("direction cleared", d, 8'h00);
        wr(fppio_pkg::IDX_PORT_D_DIRECTION, 8'hff);
        rd(fppio_pkg::IDX_PORT_D_LATCH); check("latch kept", d, 8'h3c);
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        t_reset_dirs();
        t_port_a();
        t_open_drain();
        t_takeover();
        t_bus_errors();
        t_latch_keeps();
        results();
    end
    // Whole run needs about a hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        results();
    end
endmodule
